/* File: src/hpsc_pkg.sv */
// constants for the hot-plug slot control and status register bank
package hpsc_pkg;

   // ********************************
   // register bus
   // ********************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] SLOT_CTRL_STAT_ADDR = 8'hd8;
   localparam logic [7:0] DEV_CAP_TWO_ADDR = 8'he4;

   // ********************************
   // slot control field positions (low half)
   // ********************************
   localparam int CTL_ABP_EN = 0;
   localparam int CTL_PFD_EN = 1;
   localparam int CTL_PDC_EN = 3;
   localparam int CTL_CCI_EN = 4;
   localparam int CTL_HPI_EN = 5;
   localparam int CTL_ATTN_LO = 6;
   localparam int CTL_PWR_IND_LO = 8;
   localparam int CTL_PWR_CTL = 10;
   localparam int CTL_DLLSC_EN = 12;
   localparam int IND_W = 2;

   // ********************************
   // slot status field positions (high half of the word)
   // ********************************
   localparam int STS_ABP = 16;
   localparam int STS_PFD = 17;
   localparam int STS_LATCH_CHG = 18;
   localparam int STS_PDC = 19;
   localparam int STS_CC = 20;
   localparam int STS_LATCH_STATE = 21;
   localparam int STS_PRESENCE = 22;
   localparam int STS_DLLSC = 24;

   // ********************************
   // reset values and encodings
   // ********************************
   localparam logic [1:0] IND_RESERVED = 2'h0;
   localparam logic [1:0] IND_ON = 2'h1;
   localparam logic [1:0] IND_BLINK = 2'h2;
   localparam logic [1:0] IND_OFF = 2'h3;
   localparam logic [1:0] IND_RESET = IND_OFF;
   localparam logic PWR_CTL_ON = 1'b0;
   localparam logic PWR_CTL_RESET = PWR_CTL_ON;
   localparam logic PRESENCE_RESET = 1'b1;
   localparam logic PRESENCE_NO_SLOT = 1'b1;

   // ********************************
   // device capabilities two
   // ********************************
   localparam int CAP_LTR = 11;
   localparam int CAP_OBFF_LO = 18;
   localparam logic [1:0] CAP_OBFF_VAL = 2'h1;

   // ********************************
   // pin synchroniser and link state
   // ********************************
   localparam int SYNC_STAGES = 2;
   localparam logic [1:0] START_CNT_DONE = 2'h3;
   localparam int PIN_ABP = 0;
   localparam int PIN_PFD = 1;
   localparam int PIN_LATCH = 2;
   localparam int PIN_STRAP = 3;
   localparam int PIN_SLOT_IMPL = 4;
   localparam int PIN_N = 5;

   typedef enum logic [1:0] {
      HPSC_DL_INACTIVE,
      HPSC_DL_FEATURE,
      HPSC_DL_ACTIVE
   } hpsc_dl_state_t;

endpackage

/* File: src/hpsc_pin_sync.sv */
// two-stage pin synchroniser with change detection per bit
`timescale 1ns/1ns
`default_nettype none
module hpsc_pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_core_clk,             // core clock
   input wire logic i_rstn,                 // async reset, active low
   input wire logic [WIDTH-1:0] i_pin,      // raw pin levels
   output logic [WIDTH-1:0] o_level,        // synchronised level
   output logic [WIDTH-1:0] o_rise,         // one-cycle rise pulse
   output logic [WIDTH-1:0] o_change        // one-cycle change pulse
);

   // ********************************
   // per-bit stages
   // ********************************
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         logic meta_q;
         logic sync_q;
         logic last_q;
         always_ff @(posedge i_core_clk or negedge i_rstn)
         begin
            if (!i_rstn)
            begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
               last_q <= 1'b0;
            end
            else
            begin
               meta_q <= i_pin[g];
               sync_q <= meta_q;
               last_q <= sync_q;
            end
         end
         assign o_level[g] = sync_q;
         assign o_rise[g] = sync_q & ~last_q;
         assign o_change[g] = sync_q ^ last_q;
      end
   endgenerate

endmodule
`default_nettype wire

/* File: src/hpsc_slot_regs.sv */
// hot-plug slot control, slot status and device capabilities two registers
`timescale 1ns/1ns
`default_nettype none
//
// Function
// - button event notifies only with enable bit0
// - power fault notifies only with bit1
// - presence change notifies only with bit3
// - command completion interrupts only with bit4
// - bit5 gates all hot-plug interrupts
// - attention indicator field, reset off, write sends
// - power indicator field, reset off, write sends
// - bit10 slot power: 0 on, 1 off
// - bit12 enables link-active change notification
// - button pressed sticky, write-one clears
// - power fault sticky, write-one clears
// - latch change flag, read-only
// - presence changed sticky, write-one clears
// - command completed sticky, write-one clears
// - latch state mirrors sensor, 1 open
// - presence state: 1 card present
// - no slot: presence reads one
// - presence reset value is inverted strap
// - link-active change sticky, write-one clears
// - capability bits 11 and 18 read one, rest zero
// - capability bits 19:18 read 01b
// - link active only in active state
module hpsc_slot_regs (
   input wire logic i_core_clk,                              // core clock, 100 MHz
   input wire logic i_rstn,                                  // async reset, active low
   input wire logic [hpsc_pkg::ADDR_W-1:0] i_addr,           // register byte address
   input wire logic [hpsc_pkg::DATA_W-1:0] i_wdata,          // write data
   input wire logic i_wr,                                    // write strobe
   input wire logic i_rd,                                    // read strobe
   output logic [hpsc_pkg::DATA_W-1:0] o_rdata,              // read data, cycle after read
   input wire logic i_attn_button,                           // attention button pin, high pressed
   input wire logic i_power_fault,                           // power fault pin, high fault
   input wire logic i_retention_latch,                       // latch sensor pin, high open
   input wire logic i_card_presence_strap,                   // presence strap pin, low present
   input wire logic i_slot_implemented,                      // slot implemented strap
   input wire logic i_cmd_done,                              // command finished pulse, core clock
   input wire logic [1:0] i_dl_state,                        // data link control state, core clock
   output logic [hpsc_pkg::IND_W-1:0] o_attn_ind,            // attention indicator setting
   output logic [hpsc_pkg::IND_W-1:0] o_pwr_ind,             // power indicator setting
   output logic o_attn_msg_req,                              // send attention indicator message
   output logic o_pwr_msg_req,                               // send power indicator message
   output logic o_slot_power_off,                            // slot power off request
   output logic o_hp_irq                                     // hot-plug interrupt request
);

   // ********************************
   // pin synchronisers
   // ********************************
   logic [hpsc_pkg::PIN_N-1:0] pins;
   logic [hpsc_pkg::PIN_N-1:0] pin_level;
   logic [hpsc_pkg::PIN_N-1:0] pin_rise;
   logic [hpsc_pkg::PIN_N-1:0] pin_change;

   assign pins[hpsc_pkg::PIN_ABP] = i_attn_button;
   assign pins[hpsc_pkg::PIN_PFD] = i_power_fault;
   assign pins[hpsc_pkg::PIN_LATCH] = i_retention_latch;
   assign pins[hpsc_pkg::PIN_STRAP] = i_card_presence_strap;
   assign pins[hpsc_pkg::PIN_SLOT_IMPL] = i_slot_implemented;

   hpsc_pin_sync #(
      .WIDTH(hpsc_pkg::PIN_N)
   ) u_pin_sync (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_pin(pins),
      .o_level(pin_level),
      .o_rise(pin_rise),
      .o_change(pin_change)
   );

   // ********************************
   // start-up window
   // ********************************
   // pin events are ignored until the synchronisers hold real pin levels
   logic [1:0] start_cnt_q;
   logic started;
   logic primed_q; // one cycle after started: strap load is not a change

   assign started = (start_cnt_q == hpsc_pkg::START_CNT_DONE);

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         start_cnt_q <= 2'h0;
         primed_q <= 1'b0;
      end
      else
      begin
         primed_q <= started;
         if (!started)
         begin
            start_cnt_q <= start_cnt_q + 2'h1;
         end
      end
   end

   // ********************************
   // bus decode
   // ********************************
   logic sel_slot;
   logic sel_cap;
   logic wr_slot;

   assign sel_slot = (i_addr == hpsc_pkg::SLOT_CTRL_STAT_ADDR);
   assign sel_cap = (i_addr == hpsc_pkg::DEV_CAP_TWO_ADDR);
   assign wr_slot = i_wr & sel_slot;

   // ********************************
   // slot control
   // ********************************
   logic abp_en_q;
   logic pfd_en_q;
   logic pdc_en_q;
   logic cci_en_q;
   logic hpi_en_q;
   logic dllsc_en_q;
   logic pwr_ctl_q;
   logic [hpsc_pkg::IND_W-1:0] attn_ind_q;
   logic [hpsc_pkg::IND_W-1:0] pwr_ind_q;

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         abp_en_q <= 1'b0;
         pfd_en_q <= 1'b0;
         pdc_en_q <= 1'b0;
         cci_en_q <= 1'b0;
         hpi_en_q <= 1'b0;
         dllsc_en_q <= 1'b0;
      end
      else if (wr_slot)
      begin
         abp_en_q <= i_wdata[hpsc_pkg::CTL_ABP_EN];
         pfd_en_q <= i_wdata[hpsc_pkg::CTL_PFD_EN];
         pdc_en_q <= i_wdata[hpsc_pkg::CTL_PDC_EN];
         cci_en_q <= i_wdata[hpsc_pkg::CTL_CCI_EN];
         hpi_en_q <= i_wdata[hpsc_pkg::CTL_HPI_EN];
         dllsc_en_q <= i_wdata[hpsc_pkg::CTL_DLLSC_EN];
      end
   end

   // indicators keep a written reserved code as is
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         attn_ind_q <= hpsc_pkg::IND_RESET;
         pwr_ind_q <= hpsc_pkg::IND_RESET;
      end
      else if (wr_slot)
      begin
         attn_ind_q <= i_wdata[hpsc_pkg::CTL_ATTN_LO +: hpsc_pkg::IND_W];
         pwr_ind_q <= i_wdata[hpsc_pkg::CTL_PWR_IND_LO +: hpsc_pkg::IND_W];
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         pwr_ctl_q <= hpsc_pkg::PWR_CTL_RESET;
      end
      else if (wr_slot)
      begin
         pwr_ctl_q <= i_wdata[hpsc_pkg::CTL_PWR_CTL];
      end
   end

   // ********************************
   // indicator message requests
   // ********************************
   // every write to the word carries both fields, so both messages go out
   logic attn_msg_q;
   logic pwr_msg_q;

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         attn_msg_q <= 1'b0;
         pwr_msg_q <= 1'b0;
      end
      else
      begin
         attn_msg_q <= wr_slot;
         pwr_msg_q <= wr_slot;
      end
   end

   // ********************************
   // link active tracking
   // ********************************
   logic link_active;
   logic link_active_q;
   logic link_chg;

   assign link_active = (i_dl_state == 2'(hpsc_pkg::HPSC_DL_ACTIVE));

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         link_active_q <= 1'b0;
      end
      else
      begin
         link_active_q <= link_active;
      end
   end

   assign link_chg = link_active ^ link_active_q;

   // ********************************
   // presence and latch state
   // ********************************
   logic presence_q;
   logic presence_d;
   logic presence_chg;
   logic latch_state_q;
   logic slot_impl;

   assign slot_impl = pin_level[hpsc_pkg::PIN_SLOT_IMPL];

   always_comb
   begin
      if (!slot_impl)
      begin
         presence_d = hpsc_pkg::PRESENCE_NO_SLOT;
      end
      else
      begin
         presence_d = ~pin_level[hpsc_pkg::PIN_STRAP];
      end
   end

   // strap level is taken once the synchroniser has settled after release
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         presence_q <= hpsc_pkg::PRESENCE_RESET;
      end
      else if (started)
      begin
         presence_q <= presence_d;
      end
   end

   // first load after reset only brings the state in line with the strap
   assign presence_chg = primed_q & slot_impl & (presence_q != presence_d);

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         latch_state_q <= 1'b0;
      end
      else
      begin
         latch_state_q <= pin_level[hpsc_pkg::PIN_LATCH];
      end
   end

   // ********************************
   // sticky event flags
   // ********************************
   // a set in the clearing cycle wins over the write-one clear
   logic abp_q;
   logic pfd_q;
   logic latch_chg_q;
   logic pdc_q;
   logic cc_q;
   logic dllsc_q;
   logic clr_abp;
   logic clr_pfd;
   logic clr_pdc;
   logic clr_cc;
   logic clr_dllsc;

   assign clr_abp = wr_slot & i_wdata[hpsc_pkg::STS_ABP];
   assign clr_pfd = wr_slot & i_wdata[hpsc_pkg::STS_PFD];
   assign clr_pdc = wr_slot & i_wdata[hpsc_pkg::STS_PDC];
   assign clr_cc = wr_slot & i_wdata[hpsc_pkg::STS_CC];
   assign clr_dllsc = wr_slot & i_wdata[hpsc_pkg::STS_DLLSC];

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         abp_q <= 1'b0;
         pfd_q <= 1'b0;
      end
      else
      begin
         abp_q <= (started & pin_rise[hpsc_pkg::PIN_ABP]) | (abp_q & ~clr_abp);
         pfd_q <= (started & pin_rise[hpsc_pkg::PIN_PFD]) | (pfd_q & ~clr_pfd);
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         pdc_q <= 1'b0;
         cc_q <= 1'b0;
         dllsc_q <= 1'b0;
      end
      else
      begin
         pdc_q <= presence_chg | (pdc_q & ~clr_pdc);
         cc_q <= i_cmd_done | (cc_q & ~clr_cc);
         dllsc_q <= link_chg | (dllsc_q & ~clr_dllsc);
      end
   end

   // read-only to software: only reset clears it
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         latch_chg_q <= 1'b0;
      end
      else if (started & pin_change[hpsc_pkg::PIN_LATCH])
      begin
         latch_chg_q <= 1'b1;
      end
   end

   // ********************************
   // interrupt request
   // ********************************
   logic irq_d;
   logic irq_q;

   always_comb
   begin
      irq_d = hpi_en_q &
              ((abp_q & abp_en_q) |
               (pfd_q & pfd_en_q) |
               (pdc_q & pdc_en_q) |
               (cc_q & cci_en_q) |
               (dllsc_q & dllsc_en_q));
   end

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         irq_q <= 1'b0;
      end
      else
      begin
         irq_q <= irq_d;
      end
   end

   // ********************************
   // read path
   // ********************************
   logic [hpsc_pkg::DATA_W-1:0] slot_word;
   logic [hpsc_pkg::DATA_W-1:0] cap_word;
   logic [hpsc_pkg::DATA_W-1:0] rdata_d;
   logic [hpsc_pkg::DATA_W-1:0] rdata_q;

   always_comb
   begin
      slot_word = '0;
      slot_word[hpsc_pkg::CTL_ABP_EN] = abp_en_q;
      slot_word[hpsc_pkg::CTL_PFD_EN] = pfd_en_q;
      slot_word[hpsc_pkg::CTL_PDC_EN] = pdc_en_q;
      slot_word[hpsc_pkg::CTL_CCI_EN] = cci_en_q;
      slot_word[hpsc_pkg::CTL_HPI_EN] = hpi_en_q;
      slot_word[hpsc_pkg::CTL_ATTN_LO +: hpsc_pkg::IND_W] = attn_ind_q;
      slot_word[hpsc_pkg::CTL_PWR_IND_LO +: hpsc_pkg::IND_W] = pwr_ind_q;
      slot_word[hpsc_pkg::CTL_PWR_CTL] = pwr_ctl_q;
      slot_word[hpsc_pkg::CTL_DLLSC_EN] = dllsc_en_q;
      slot_word[hpsc_pkg::STS_ABP] = abp_q;
      slot_word[hpsc_pkg::STS_PFD] = pfd_q;
      slot_word[hpsc_pkg::STS_LATCH_CHG] = latch_chg_q;
      slot_word[hpsc_pkg::STS_PDC] = pdc_q;
      slot_word[hpsc_pkg::STS_CC] = cc_q;
      slot_word[hpsc_pkg::STS_LATCH_STATE] = latch_state_q;
      slot_word[hpsc_pkg::STS_PRESENCE] = presence_q;
      slot_word[hpsc_pkg::STS_DLLSC] = dllsc_q;
   end

   always_comb
   begin
      cap_word = '0;
      cap_word[hpsc_pkg::CAP_LTR] = 1'b1;
      cap_word[hpsc_pkg::CAP_OBFF_LO +: 2] = hpsc_pkg::CAP_OBFF_VAL;
   end

   always_comb
   begin
      rdata_d = '0;
      if (sel_slot)
      begin
         rdata_d = slot_word;
      end
      else if (sel_cap)
      begin
         rdata_d = cap_word;
      end
   end

   // data stand only in the cycle after the read strobe
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         rdata_q <= '0;
      end
      else if (i_rd)
      begin
         rdata_q <= rdata_d;
      end
      else
      begin
         rdata_q <= '0;
      end
   end

   // ********************************
   // outputs
   // ********************************
   assign o_rdata = rdata_q;
   assign o_attn_ind = attn_ind_q;
   assign o_pwr_ind = pwr_ind_q;
   assign o_attn_msg_req = attn_msg_q;
   assign o_pwr_msg_req = pwr_msg_q;
   assign o_slot_power_off = pwr_ctl_q;
   assign o_hp_irq = irq_q;

endmodule
`default_nettype wire

/* File: tb/hpsc_slot_regs_checker.sv */
// assertion checker for the hot-plug slot register bank
`timescale 1ns/1ns
`default_nettype none
module hpsc_slot_regs_checker (
   input wire logic i_core_clk, // clock
   input wire logic i_rstn, // reset, active low
   input wire logic [hpsc_pkg::ADDR_W-1:0] i_addr, // address
   input wire logic [hpsc_pkg::DATA_W-1:0] i_wdata, // write data
   input wire logic i_wr, // write strobe
   input wire logic i_rd, // read strobe
   input wire logic [hpsc_pkg::DATA_W-1:0] o_rdata, // read data
   input wire logic [hpsc_pkg::IND_W-1:0] o_attn_ind, // attention setting
   input wire logic [hpsc_pkg::IND_W-1:0] o_pwr_ind, // power setting
   input wire logic o_attn_msg_req, // attention message
   input wire logic o_pwr_msg_req, // power message
   input wire logic o_slot_power_off, // power off request
   input wire logic o_hp_irq // interrupt request
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rstn);
   logic wr_ctl;
   logic rd_cap;
   assign wr_ctl = i_wr && (i_addr == hpsc_pkg::SLOT_CTRL_STAT_ADDR);
   assign rd_cap = i_rd && (i_addr == hpsc_pkg::DEV_CAP_TWO_ADDR);
   a_msg_on_write: assert property (wr_ctl |=> o_attn_msg_req && o_pwr_msg_req)
      else $error("indicator message missing after write");
   a_msg_no_write: assert property (!wr_ctl |=> !o_attn_msg_req && !o_pwr_msg_req)
      else $error("indicator message without write");
   a_attn_ind_load: assert property (wr_ctl |=> o_attn_ind == $past(i_wdata[7:6]))
      else $error("attention setting not loaded");
   a_pwr_ind_load: assert property (wr_ctl |=> o_pwr_ind == $past(i_wdata[9:8]))
      else $error("power setting not loaded");
   a_power_ctl_load: assert property (wr_ctl |=> o_slot_power_off == $past(i_wdata[10]))
      else $error("power control not loaded");
   a_ctl_hold: assert property (!wr_ctl |=> $stable(o_slot_power_off) && $stable(o_attn_ind))
      else $error("control changed without write");
   a_cap_word: assert property (rd_cap |=> o_rdata == 32'h0004_0800)
      else $error("capability word wrong");
   a_ctl_readback: assert property (wr_ctl ##1 (i_rd && i_addr == hpsc_pkg::SLOT_CTRL_STAT_ADDR)
      |=> o_rdata[15:0] == ($past(i_wdata[15:0], 2) & 16'h17fb))
      else $error("control readback wrong");
   a_master_gate: assert property ((wr_ctl && !i_wdata[5]) ##1 !wr_ctl |=> !o_hp_irq)
      else $error("interrupt without master enable");
   c_write: cover property (wr_ctl);
   c_cap_read: cover property (rd_cap);
   c_irq_rise: cover property ($rose(o_hp_irq));
endmodule
bind hpsc_slot_regs hpsc_slot_regs_checker i_chk (
   .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .o_attn_ind(o_attn_ind), .o_pwr_ind(o_pwr_ind),
   .o_attn_msg_req(o_attn_msg_req), .o_pwr_msg_req(o_pwr_msg_req),
   .o_slot_power_off(o_slot_power_off), .o_hp_irq(o_hp_irq)
);
`default_nettype wire

/* File: tb/hpsc_slot_model.sv */
// slot hardware model: button, supply fault, latch and card presence pins
`timescale 1ns/1ns
`default_nettype none
module hpsc_slot_model (
   input wire logic i_core_clk, // core clock
   input wire logic i_press, // one-cycle press request
   input wire logic i_slow, // hold the button longer
   input wire logic i_fault, // supply fault condition
   input wire logic i_card_in, // card inserted
   input wire logic i_latch_open, // latch opened
   input wire logic i_power_off, // slot power off request
   output logic o_attn_button, // button pin, high pressed
   output logic o_power_fault, // fault pin
   output logic o_retention_latch, // latch pin, high open
   output logic o_card_presence_strap // presence pin, low present
);
   logic [3:0] hold_q = 4'h0;
   // a press is held long enough to pass the pin filter
   always_ff @(posedge i_core_clk)
   begin
      if (i_press)
         hold_q <= i_slow ? 4'h8 : 4'h4;
      else if (hold_q != 4'h0)
         hold_q <= hold_q - 4'h1;
   end
   assign o_attn_button = (hold_q != 4'h0);
   // an unpowered slot cannot report a supply fault
   assign o_power_fault = i_fault && !i_power_off;
   assign o_retention_latch = i_latch_open;
   assign o_card_presence_strap = !i_card_in;
endmodule
`default_nettype wire

/* File: tb/test_hpsc_slot_regs.sv */
// self-checking bench for the hot-plug slot register bank
`timescale 1ns/1ns
`default_nettype none
module test_hpsc_slot_regs;
   localparam logic [7:0] A_SS = hpsc_pkg::SLOT_CTRL_STAT_ADDR;
   localparam logic [7:0] A_CAP = hpsc_pkg::DEV_CAP_TWO_ADDR;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic cmd_done = 1'b0;
   logic slot_impl = 1'b1;
   logic [1:0] dl_state = 2'h1;
   logic press = 1'b0;
   logic slow = 1'b0;
   logic fault = 1'b0;
   logic card_in = 1'b1;
   logic latch_open = 1'b0;
   logic [31:0] rdata;
   logic [1:0] attn_ind;
   logic [1:0] pwr_ind;
   logic power_off;
   logic hp_irq;
   logic btn_pin;
   logic fault_pin;
   logic latch_pin;
   logic strap_pin;
   logic [31:0] seen;
   logic [5:0] outs;
   logic [31:0] v;
   logic [15:0] ctl;
   int en_pos[5] = '{0, 1, 3, 4, 12};
   int st_pos[5] = '{16, 17, 19, 20, 24};
   int err_count = 0;
   int checks_done = 0;

   hpsc_slot_regs i_hpsc_slot_regs (
      .i_core_clk(core_clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .i_attn_button(btn_pin), .i_power_fault(fault_pin), .i_retention_latch(latch_pin),
      .i_card_presence_strap(strap_pin), .i_slot_implemented(slot_impl), .i_cmd_done(cmd_done),
      .i_dl_state(dl_state), .o_attn_ind(attn_ind), .o_pwr_ind(pwr_ind), .o_attn_msg_req(),
      .o_pwr_msg_req(), .o_slot_power_off(power_off), .o_hp_irq(hp_irq)
   );
   hpsc_slot_model i_hpsc_slot_model (
      .i_core_clk(core_clk), .i_press(press), .i_slow(slow), .i_fault(fault), .i_card_in(card_in),
      .i_latch_open(latch_open), .i_power_off(power_off), .o_attn_button(btn_pin),
      .o_power_fault(fault_pin), .o_retention_latch(latch_pin), .o_card_presence_strap(strap_pin)
   );

   initial forever #5 core_clk = !core_clk;

   // ****************************
   // bus and check tasks
   // ****************************
   task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   // leaves the strobe up so back-to-back writes never double-assign it
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      wr <= 1'b1;
      rd <= 1'b0;
      addr <= a;
      wdata <= d;
      @(posedge core_clk);
   endtask
   task automatic idle(input int n);
      wr <= 1'b0;
      repeat (n) @(posedge core_clk);
   endtask
   task automatic rd_reg(input logic [7:0] a);
      wr <= 1'b0;
      rd <= 1'b1;
      addr <= a;
      @(posedge core_clk);
      rd <= 1'b0;
      @(negedge core_clk);
      seen = rdata;
      outs = {attn_ind, pwr_ind, power_off, hp_irq};
      @(posedge core_clk);
   endtask
   task automatic trigger(input int e, input int ph);
      if (e == 0)
         press <= 1'b1;
      if (e == 1)
         fault <= 1'b1;
      if (e == 2)
         card_in <= !card_in;
      if (e == 3)
         cmd_done <= 1'b1;
      if (e == 4)
         dl_state <= (dl_state == 2'h2) ? 2'h1 : 2'h2;
      slow <= (ph == 1);
      @(posedge core_clk);
      press <= 1'b0;
      cmd_done <= 1'b0;
      repeat (8) @(posedge core_clk);
      fault <= 1'b0;
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ****************************
   // test sequence
   // ****************************
   initial
   begin
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      idle(5);
      rd_reg(A_SS);
      chk("reset slot word", seen, 32'h0040_03c0);
      chk("reset outputs", outs, 32'h3c);
      wr_reg(A_CAP, 32'hffff_ffff);
      rd_reg(A_CAP);
      chk("capability word", seen, 32'h0004_0800);
      rd_reg(8'hdc);
      chk("unmapped read", seen, 32'h0);
      $display("test reset values done");
      for (int k = 0; k < 4; k++)
      begin
         v = 32'h0000_e804;
         v[7:6] = k[1:0];
         v[9:8] = 2'h3 - k[1:0];
         v[10] = k[0];
         v[12] = k[1];
         v[5:0] = v[5:0] | (k[0] ? 6'h1b : 6'h20);
         wr_reg(A_SS, v);
         rd_reg(A_SS);
         chk("control word", seen, {16'h0040, v[15:0] & 16'h17fb});
         chk("control pins", outs, {k[1:0], 2'h3 - k[1:0], k[0], 1'b0});
      end
      $display("test control field done");
      for (int e = 0; e < 5; e++)
      begin
         for (int ph = 0; ph < 3; ph++)
         begin
            ctl = 16'h03c0;
            if (ph != 2)
               ctl[en_pos[e]] = 1'b1;
            if (ph != 1)
               ctl[5] = 1'b1;
            wr_reg(A_SS, {16'h0, ctl});
            idle(2);
            trigger(e, ph);
            idle(10);
            rd_reg(A_SS);
            chk("event flag", seen[st_pos[e]], 1'b1);
            chk("event irq", outs[0], ph == 0);
            wr_reg(A_SS, {16'h0, ctl} | (32'h1 << st_pos[e]));
            idle(3);
            rd_reg(A_SS);
            chk("flag cleared", seen[st_pos[e]], 1'b0);
            chk("irq cleared", outs[0], 1'b0);
         end
      end
      $display("test events done");
      latch_open <= 1'b1;
      dl_state <= 2'h0;
      idle(6);
      wr_reg(A_SS, 32'h0166_03c0);
      rd_reg(A_SS);
      chk("latch bits", seen[22:18], 5'b01001);
      slot_impl <= 1'b0;
      dl_state <= 2'h1;
      idle(6);
      rd_reg(A_SS);
      chk("no slot presence", seen[22], 1'b1);
      chk("feature not active", seen[24], 1'b0);
      $display("test latch and presence done");
      slot_impl <= 1'b1;
      rstn <= 1'b0;
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      idle(5);
      rd_reg(A_SS);
      chk("slot word after reset", seen, 32'h0020_03c0);
      $display("test strap reset done");
      wrap_up();
   end

   // whole run is near 510 cycles; allow about twenty times that
   initial
   begin
      #100000;
      err_count++;
      wrap_up();
   end
endmodule
`default_nettype wire
